// [hst_map.svh]
// register-free constant map for the host select and transfer front end
`ifndef HST_MAP_SVH
`define HST_MAP_SVH
`define HST_CLK_NS 50
`define HST_STB_DLY_NS 300
`define HST_DRW_DLY_NS 3400
`define HST_RESP_MAX_NS 4000
`define HST_POR_MS 300
`define HST_STB_CYC ((`HST_STB_DLY_NS + `HST_CLK_NS - 1) / `HST_CLK_NS)
`define HST_DRW_CYC ((`HST_DRW_DLY_NS + `HST_CLK_NS - 1) / `HST_CLK_NS)
`define HST_RESP_CYC (`HST_RESP_MAX_NS / `HST_CLK_NS)
`define HST_POR_CYC (`HST_POR_MS * 1000000 / `HST_CLK_NS)
`define HST_POR_W 23
`define HST_DLY_W 7
`define HST_AGE_W 8
`define HST_EQ_HI 10
`define HST_EQ_LO 7
`define HST_DIRECT_BIT 4
`define HST_ADDR_HI 3
`define HST_ADDR_LO 0
`endif

// [hst_pkg.sv]
// types shared by the host select and transfer front end
package hst_pkg;
   typedef logic [10:0] hst_code_t;
   typedef logic [3:0] hst_nib_t;
   typedef logic [6:0] hst_dly_t;
   typedef enum logic [1:0] {HST_IDLE, HST_DLY, HST_XFER, HST_RESP} hst_state_t;
endpackage

// [hst_dly_if.sv]
// start, length and done of the shared delay timer
`timescale 1ns/1ps
interface hst_dly_if;
   logic start;
   hst_pkg::hst_dly_t limit;
   logic done;
   modport timer (input start, input limit, output done);
   modport user (output start, output limit, input done);
endinterface

// [hst_delay.sv]
// one-shot down counter that times the strobe delays
`timescale 1ns/1ps
`include "hst_map.svh"
module hst_delay (
   input wire logic mclk,
   input wire logic rst,
   hst_dly_if.timer t
);
   import hst_pkg::*;
   hst_dly_t cnt_reg;
   hst_dly_t cnt_next;

   always_comb begin
      if (t.start) begin
         cnt_next = t.limit;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 7'h01;
      end else begin
         cnt_next = cnt_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign t.done = (cnt_reg == 7'h01);

   load_then_count_a: assert property (@(posedge mclk) disable iff (rst)
      t.start |=> cnt_reg == $past(t.limit))
      else $error("delay timer did not load its length");
endmodule

// [hst_top.sv]
// host select, protect and transfer-timing front end
`timescale 1ns/1ps
`include "hst_map.svh"
module hst_top #(
   parameter int unsigned POR_CYCLES = `HST_POR_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire hst_pkg::hst_code_t sel_code,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic protect_line,
   input wire logic master_clear,
   input wire hst_pkg::hst_nib_t equip_switch,
   input wire logic protect_switch,
   output logic reply,
   output logic reject,
   output logic unit_chosen_flag,
   output logic protect_flag,
   output logic read_strobe_int,
   output logic write_strobe_int,
   output logic either_transfer_strobe,
   output logic chosen_transfer_strobe,
   output logic delayed_transfer_strobe,
   output logic sel_inhibit,
   output logic counter_load,
   output logic counter_advance,
   output hst_pkg::hst_nib_t counter_addr,
   output logic counter_clear,
   output logic interrupt_mask_clear,
   output logic term_clear
);
   import hst_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // state

   hst_dly_if dly ();

   hst_delay u_delay (
      .mclk(mclk),
      .rst(rst),
      .t(dly.timer)
   );

   hst_state_t state_reg, state_next;
   hst_code_t code_reg, code_next;
   logic is_wr_reg, is_wr_next;
   logic prot_line_reg, prot_line_next;
   logic req_prev_reg, req_prev_next;
   logic gclr_prev_reg, gclr_prev_next;
   logic [`HST_AGE_W-1:0] age_reg, age_next;
   logic [`HST_POR_W-1:0] por_cnt_reg, por_cnt_next;
   logic reply_next, reject_next, chosen_next, prot_next;
   logic rd_next, wr_next, either_next, cts_next, drw_next, inh_next;
   logic load_next, adv_next, cclr_next, imc_next, tclr_next;
   hst_nib_t addr_next;
   logic por_active, gclr, req, accept, match;

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      por_active = (por_cnt_reg != POR_CYCLES[`HST_POR_W-1:0]);
      gclr = master_clear | por_active;
      req = rd_strobe | wr_strobe;
      accept = (state_reg == HST_IDLE) && req && !req_prev_reg && !gclr;
      match = (code_reg[`HST_EQ_HI:`HST_EQ_LO] == equip_switch);

      state_next = state_reg;
      code_next = code_reg;
      is_wr_next = is_wr_reg;
      prot_line_next = prot_line_reg;
      reply_next = reply;
      reject_next = reject;
      chosen_next = unit_chosen_flag;
      prot_next = protect_flag;
      rd_next = read_strobe_int;
      wr_next = write_strobe_int;
      either_next = either_transfer_strobe;
      cts_next = chosen_transfer_strobe;
      drw_next = delayed_transfer_strobe;
      inh_next = sel_inhibit;
      load_next = counter_load;
      adv_next = 1'b0;
      addr_next = counter_addr;
      dly.start = 1'b0;
      dly.limit = '0;

      unique case (state_reg)
         HST_IDLE: begin
            if (accept) begin
               code_next = sel_code;
               is_wr_next = wr_strobe;
               prot_line_next = protect_line;
               dly.start = 1'b1;
               dly.limit = 7'(`HST_STB_CYC);
               state_next = HST_DLY;
            end
         end
         HST_DLY: begin
            if (dly.done) begin
               rd_next = !is_wr_reg;
               wr_next = is_wr_reg;
               either_next = 1'b1;
               chosen_next = match;
               prot_next = protect_switch ? prot_line_reg : 1'b1;
               cts_next = match && prot_next;
               inh_next = !cts_next;
               load_next = cts_next && code_reg[`HST_DIRECT_BIT];
               adv_next = cts_next && !code_reg[`HST_DIRECT_BIT] && is_wr_reg;
               if (load_next) begin
                  addr_next = code_reg[`HST_ADDR_HI:`HST_ADDR_LO];
               end
               dly.start = 1'b1;
               dly.limit = 7'(`HST_DRW_CYC);
               state_next = HST_XFER;
            end
         end
         HST_XFER: begin
            if (dly.done) begin
               drw_next = 1'b1;
               reply_next = unit_chosen_flag && protect_flag;
               reject_next = unit_chosen_flag && !protect_flag;
               state_next = HST_RESP;
            end
         end
         HST_RESP: begin
            if (!req) begin
               rd_next = 1'b0;
               wr_next = 1'b0;
               either_next = 1'b0;
               cts_next = 1'b0;
               drw_next = 1'b0;
               inh_next = 1'b1;
               load_next = 1'b0;
               reply_next = 1'b0;
               reject_next = 1'b0;
               state_next = HST_IDLE;
            end
         end
      endcase

      if (gclr) begin
         state_next = HST_IDLE;
         chosen_next = 1'b0;
         rd_next = 1'b0;
         wr_next = 1'b0;
         either_next = 1'b0;
         cts_next = 1'b0;
         drw_next = 1'b0;
         inh_next = 1'b1;
         load_next = 1'b0;
         adv_next = 1'b0;
         reply_next = 1'b0;
         reject_next = 1'b0;
      end

      tclr_next = gclr;
      cclr_next = gclr;
      imc_next = gclr && !gclr_prev_reg;
      gclr_prev_next = gclr;
      req_prev_next = req;
      por_cnt_next = por_active ? por_cnt_reg + 23'h000001 : por_cnt_reg;
      if (accept) begin
         age_next = '0;
      end else if (age_reg == 8'hff) begin
         age_next = age_reg;
      end else begin
         age_next = age_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= HST_IDLE;
         code_reg <= '0;
         is_wr_reg <= 1'b0;
         prot_line_reg <= 1'b0;
         req_prev_reg <= 1'b0;
         gclr_prev_reg <= 1'b0;
         age_reg <= '0;
         por_cnt_reg <= '0;
         reply <= 1'b0;
         reject <= 1'b0;
         unit_chosen_flag <= 1'b0;
         protect_flag <= 1'b0;
         read_strobe_int <= 1'b0;
         write_strobe_int <= 1'b0;
         either_transfer_strobe <= 1'b0;
         chosen_transfer_strobe <= 1'b0;
         delayed_transfer_strobe <= 1'b0;
         sel_inhibit <= 1'b1;
         counter_load <= 1'b0;
         counter_advance <= 1'b0;
         counter_addr <= '0;
         counter_clear <= 1'b0;
         interrupt_mask_clear <= 1'b0;
         term_clear <= 1'b0;
      end else begin
         state_reg <= state_next;
         code_reg <= code_next;
         is_wr_reg <= is_wr_next;
         prot_line_reg <= prot_line_next;
         req_prev_reg <= req_prev_next;
         gclr_prev_reg <= gclr_prev_next;
         age_reg <= age_next;
         por_cnt_reg <= por_cnt_next;
         reply <= reply_next;
         reject <= reject_next;
         unit_chosen_flag <= chosen_next;
         protect_flag <= prot_next;
         read_strobe_int <= rd_next;
         write_strobe_int <= wr_next;
         either_transfer_strobe <= either_next;
         chosen_transfer_strobe <= cts_next;
         delayed_transfer_strobe <= drw_next;
         sel_inhibit <= inh_next;
         counter_load <= load_next;
         counter_advance <= adv_next;
         counter_addr <= addr_next;
         counter_clear <= cclr_next;
         interrupt_mask_clear <= imc_next;
         term_clear <= tclr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   strobe_delay_a: assert property ($rose(either_transfer_strobe) |->
      age_reg == `HST_STB_CYC && (read_strobe_int != write_strobe_int))
      else $error("either strobe not at the short delay");
   drw_delay_a: assert property ($rose(delayed_transfer_strobe) |->
      age_reg == `HST_STB_CYC + `HST_DRW_CYC && either_transfer_strobe)
      else $error("delayed strobe off its delay");
   resp_deadline_a: assert property ($rose(reply || reject) |->
      age_reg < `HST_RESP_CYC && delayed_transfer_strobe)
      else $error("response late or early");
   resp_excl_a: assert property (!(reply && reject))
      else $error("reply and reject together");
   resp_gate_a: assert property ((reply || reject) |-> either_transfer_strobe)
      else $error("response without either strobe");
   sel_clear_a: assert property ((state_reg == HST_DLY) && dly.done && !match && !gclr
      |=> !unit_chosen_flag && !reply && !reject)
      else $error("mismatch left unit chosen");
   chosen_gate_a: assert property (!unit_chosen_flag |->
      !chosen_transfer_strobe && !counter_advance && !counter_load)
      else $error("chosen strobe without selection");
   prot_gate_a: assert property (!protect_flag |-> !chosen_transfer_strobe && sel_inhibit)
      else $error("protect flag clear but strobe raised");
   gclr_fwd_a: assert property (master_clear |=>
      term_clear && counter_clear && !unit_chosen_flag && !either_transfer_strobe)
      else $error("general clear not forwarded");
   mask_pulse_a: assert property ($rose(term_clear) |-> interrupt_mask_clear ##1
      !interrupt_mask_clear)
      else $error("mask clear not a single pulse");
   por_clear_a: assert property (por_active |=> term_clear)
      else $error("power-up clear missing");
   unprot_set_a: assert property ($rose(either_transfer_strobe) && !$past(protect_switch)
      |-> protect_flag)
      else $error("unprotected mode left protect flag clear");
   direct_load_a: assert property (counter_load |-> code_reg[`HST_DIRECT_BIT] &&
      counter_addr == code_reg[`HST_ADDR_HI:`HST_ADDR_LO])
      else $error("direct address not loaded");
endmodule

// [hst_host_model.sv]
// host i/o channel model: issues one select code per read or write strobe
`timescale 1ns/1ps
module hst_host_model (
   input wire logic mclk,
   input wire logic reply,
   input wire logic reject,
   input wire logic either_transfer_strobe,
   output hst_pkg::hst_code_t sel_code,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic protect_line
);
   import hst_pkg::*;
   initial begin
      sel_code = 11'h000;
      rd_strobe = 1'b0;
      wr_strobe = 1'b0;
      protect_line = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one transfer: hold strobe and code until reply or reject, or for at most 101 cycles, then release
   task automatic xfer(input logic w, input hst_code_t c, input logic p,
                       output logic rp, output logic rj, output int t_e, output int t_r);
      int n;
      @(negedge mclk);
      sel_code = {c[10:7], 2'b00, c[4:0]};
      protect_line = p;
      rd_strobe = ~w;
      wr_strobe = w;
      n = -1;
      t_e = -1;
      rp = 1'b0;
      rj = 1'b0;
      while (n < 100 && rp !== 1'b1 && rj !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (either_transfer_strobe === 1'b1 && t_e < 0) begin
            t_e = n;
         end
         rp = reply;
         rj = reject;
      end
      t_r = n;
      rd_strobe = 1'b0;
      wr_strobe = 1'b0;
      sel_code = {~c[10:7], 2'b00, ~c[4:0]};
      protect_line = ~p;
      @(negedge mclk);
      @(negedge mclk);
   endtask
endmodule

// [hst_top_tb_top.sv]
// self-checking bench for the host select and transfer front end
`timescale 1ns/1ps
module hst_top_tb_top;
   import hst_pkg::*;
   localparam int POR = 20;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic master_clear = 1'b0;
   hst_nib_t equip_switch = 4'ha;
   logic protect_switch = 1'b1;
   hst_code_t sel_code;
   logic rd_strobe, wr_strobe, protect_line, reply, reject, unit_chosen_flag, protect_flag;
   logic read_strobe_int, write_strobe_int, either_transfer_strobe, chosen_transfer_strobe;
   logic delayed_transfer_strobe, sel_inhibit, counter_load, counter_advance, counter_clear;
   logic interrupt_mask_clear, term_clear, eith_q;
   logic [2:0] rw_snap;
   logic drw_seen;
   hst_nib_t counter_addr;
   logic [6:0] snap;
   int num_errors = 0;
   int total_checks = 0;
   int adv_cnt = 0;
   int mclr_cnt = 0;
   always #25 mclk = ~mclk;
   hst_top #(.POR_CYCLES(POR)) DUT (.mclk(mclk), .rst(rst), .sel_code(sel_code),
      .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .protect_line(protect_line),
      .master_clear(master_clear), .equip_switch(equip_switch),
      .protect_switch(protect_switch), .reply(reply), .reject(reject),
      .unit_chosen_flag(unit_chosen_flag), .protect_flag(protect_flag),
      .read_strobe_int(read_strobe_int), .write_strobe_int(write_strobe_int),
      .either_transfer_strobe(either_transfer_strobe),
      .chosen_transfer_strobe(chosen_transfer_strobe),
      .delayed_transfer_strobe(delayed_transfer_strobe), .sel_inhibit(sel_inhibit),
      .counter_load(counter_load), .counter_advance(counter_advance),
      .counter_addr(counter_addr), .counter_clear(counter_clear),
      .interrupt_mask_clear(interrupt_mask_clear), .term_clear(term_clear));
   hst_host_model HOST (.mclk(mclk), .reply(reply), .reject(reject),
      .either_transfer_strobe(either_transfer_strobe), .sel_code(sel_code),
      .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .protect_line(protect_line));
   ////////////////////////////////////////////////////////////////////////////////
   // snapshot of select outputs when a transfer starts, pulse counters
   always @(negedge mclk) begin
      if (either_transfer_strobe === 1'b1 && eith_q !== 1'b1) begin
         snap = {chosen_transfer_strobe, sel_inhibit, counter_load, counter_addr};
         rw_snap = {read_strobe_int, write_strobe_int, delayed_transfer_strobe};
      end
      if (reply === 1'b1 || reject === 1'b1) begin
         drw_seen = delayed_transfer_strobe;
      end
      eith_q = either_transfer_strobe;
      if (counter_advance === 1'b1) adv_cnt++;
      if (interrupt_mask_clear === 1'b1) mclr_cnt++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (num_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   function automatic hst_code_t code(input hst_nib_t eq, input logic d, input hst_nib_t a);
      return {eq, 2'b00, d, a};
   endfunction
   task automatic tx(input logic w, input hst_code_t c, input logic p, input logic [1:0] er);
      logic rp, rj;
      int te, tr;
      adv_cnt = 0;
      drw_seen = 1'b0;
      HOST.xfer(w, c, p, rp, rj, te, tr);
      check({rp, rj}, er);
      if (er != 2'b00) begin
         check(te, 6);
         check((tr - te >= 64) && (tr - te <= 72), 1);
         check(tr < 80, 1);
         check({rw_snap, drw_seen}, {~w, w, 2'b01});
      end
   endtask
   initial begin
      #(5000 * 50);
      num_errors++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge mclk);
      check({sel_inhibit, term_clear, reply, unit_chosen_flag}, 4'h8);
      rst = 1'b0;
      @(negedge mclk);
      check({term_clear, counter_clear, interrupt_mask_clear}, 3'h7);
      repeat (POR + 2) @(negedge mclk);
      check({term_clear, mclr_cnt[3:0]}, 5'h01);
      for (int e = 0; e < 16; e++) begin
         equip_switch = e[3:0];
         tx(1'b0, code(e[3:0], 1'b1, e[3:0]), 1'b1, 2'b10);
         check(snap, {3'b101, e[3:0]});
         check({unit_chosen_flag, protect_flag}, 2'b11);
      end
      tx(1'b1, code(4'hf, 1'b0, 4'h3), 1'b1, 2'b10);
      check({snap, adv_cnt[1:0]}, {7'h4f, 2'h1});
      tx(1'b0, code(4'hf, 1'b1, 4'h2), 1'b0, 2'b01);
      check({snap[6:5], protect_flag}, 3'b010);
      protect_switch = 1'b0;
      tx(1'b1, code(4'hf, 1'b1, 4'h6), 1'b0, 2'b10);
      check({protect_flag, counter_addr, adv_cnt[1:0]}, {1'b1, 4'h6, 2'h0});
      tx(1'b0, code(4'hf, 1'b1, 4'h1), 1'b0, 2'b10);
      protect_switch = 1'b1;
      tx(1'b1, code(4'h7, 1'b0, 4'h1), 1'b1, 2'b00);
      check({unit_chosen_flag, adv_cnt[1:0]}, 3'h0);
      tx(1'b0, code(4'hf, 1'b1, 4'h9), 1'b1, 2'b10);
      mclr_cnt = 0;
      master_clear = 1'b1;
      repeat (2) @(negedge mclk);
      check({term_clear, counter_clear, unit_chosen_flag, mclr_cnt[3:0]}, 7'h61);
      tx(1'b0, code(4'hf, 1'b1, 4'h9), 1'b1, 2'b00);
      master_clear = 1'b0;
      repeat (3) @(negedge mclk);
      check({term_clear, mclr_cnt[3:0]}, 5'h01);
      tx(1'b0, code(4'hf, 1'b1, 4'h4), 1'b1, 2'b10);
      check(counter_addr, 4'h4);
      results();
   end
endmodule
